/* sim/i2c_host_model.sv */
// Serial bus master model facing the clock block
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model #(
    parameter int HALF = 8
)
(
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_rel
);
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    ////////////////////////////////////////
    // start and repeated start
    task automatic start_cond();
        sda_rel <= 1'b1;
        idle(HALF / 2);
        scl <= 1'b1;
        idle(HALF);
        sda_rel <= 1'b0;
        idle(HALF);
        scl <= 1'b0;
        idle(HALF / 2);
    endtask

    task automatic stop_cond(input int gap);
        sda_rel <= 1'b0;
        idle(HALF / 2);
        scl <= 1'b1;
        idle(HALF);
        sda_rel <= 1'b1;
        idle(gap);
    endtask

    // msb first, ninth bit is the acknowledge
    task automatic xfer(input logic [7:0] tx, input logic ninth, output logic [7:0] rx,
                        output logic ack);
        logic [8:0] sh;
        sh = {tx, ninth};
        for (int i = 8; i >= 0; i--)
        begin
            sda_rel <= sh[i];
            idle(HALF / 2);
            scl <= 1'b1;
            idle(HALF / 2);
            sh[i] = sda_line;
            idle(HALF / 2);
            scl <= 1'b0;
            idle(HALF / 2);
        end
        rx = sh[8:1];
        ack = ~sh[0];
    endtask
endmodule
`default_nettype wire

/* sim/rtc_access_chk.sv */
// Port timing checks of the serial access and trim block
`timescale 1ns/100ps
`default_nettype none
module rtc_access_chk
    import rtc_access_pkg::*;
#(
    parameter int RELEASE_OSC_TICKS = RELEASE_TICKS
)
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_N,
    input wire logic SUB_CLOCK_OUTPUT,
    input wire logic SECOND_CARRY,
    input wire logic ACCESS_HOLD,
    input wire logic INTR_PULSE_N
);
    logic [12:0] half_cnt_ff;
    logic sub_prev_ff;
    logic seen_ff;

    // First half period after reset has no reference edge, so it is skipped
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            half_cnt_ff <= 13'h0000;
            sub_prev_ff <= 1'b0;
            seen_ff <= 1'b0;
        end
        else
        begin
            sub_prev_ff <= SUB_CLOCK_OUTPUT;
            half_cnt_ff <= (SUB_CLOCK_OUTPUT != sub_prev_ff) ? 13'h0000 : half_cnt_ff + 13'h0001;
            seen_ff <= seen_ff | (SUB_CLOCK_OUTPUT != sub_prev_ff);
        end
    end

    ////////////////////////////////////////
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);

    chk_hold_start:
    assert property ($fell(SDA_IN) && SCL_IN && $past(SCL_IN) |-> ##[1:8] ACCESS_HOLD)
    else $error("hold not raised after start");
    chk_hold_stop:
    assert property ($rose(SDA_IN) && SCL_IN && $past(SCL_IN) |-> ##[1:8] !ACCESS_HOLD)
    else $error("hold not released after stop");
    chk_carry_held:
    assert property (ACCESS_HOLD && $past(ACCESS_HOLD) |-> !SECOND_CARRY)
    else $error("carry during hold");
    chk_carry_pulse:
    assert property (SECOND_CARRY |=> !SECOND_CARRY)
    else $error("carry longer than one cycle");
    chk_oe_scl_low:
    assert property ($changed(SDA_OE_N) && ACCESS_HOLD |-> !SCL_IN)
    else $error("data line changed with clock high");
    chk_oe_idle:
    assert property (!ACCESS_HOLD && !$past(ACCESS_HOLD, 2) |-> SDA_OE_N)
    else $error("data line driven outside access");
    chk_subclk_half:
    assert property ($changed(SUB_CLOCK_OUTPUT) && seen_ff |-> half_cnt_ff == HALF_DIV - 13'h0001)
    else $error("sub clock half period wrong");
    chk_subclk_runs:
    assert property (half_cnt_ff <= HALF_DIV)
    else $error("sub clock stalled");
endmodule

bind rtc_i2c_access_and_trim rtc_access_chk #(.RELEASE_OSC_TICKS(RELEASE_OSC_TICKS)) u_rtc_access_chk (
    .CLOCK(CLOCK),
    .RST(RST),
    .SCL_IN(SCL_IN),
    .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT),
    .SDA_OE_N(SDA_OE_N),
    .SUB_CLOCK_OUTPUT(SUB_CLOCK_OUTPUT),
    .SECOND_CARRY(SECOND_CARRY),
    .ACCESS_HOLD(ACCESS_HOLD),
    .INTR_PULSE_N(INTR_PULSE_N)
);
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench of the serial access and trim block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
        miscompares++; \
        $display("CHECK FAILED %0t: got %h want %h", $time, got, exp); \
    end \
end
module tb_top;
    import rtc_access_pkg::*;
    localparam int REL_TICKS = 8;
    localparam int OSC_CLKS = 7628;
    localparam int GAP_CLKS = 15250;
    localparam int LIMIT = 95000;
    localparam logic [7:0] ADR_W = {SLAVE_ADDR, 1'b0};
    localparam logic [7:0] ADR_R = {SLAVE_ADDR, 1'b1};
    logic clock;
    logic rst;
    logic scl;
    logic sda_rel;
    wire logic sda_line;
    logic sda_out, sda_oe_n, sub_clk, carry, hold, intr_n;
    int miscompares = 0, samples_checked = 0, cycles = 0, seed = 11, t0;
    logic [7:0] exp_reg [16];
    logic [7:0] rx, d;
    logic ak;

    // Open drain with pull-up
    assign sda_line = sda_rel & sda_oe_n;

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    rtc_i2c_access_and_trim #(.RELEASE_OSC_TICKS(REL_TICKS)) u_rtc_i2c_access_and_trim (
        .CLOCK(clock),
        .RST(rst),
        .SCL_IN(scl),
        .SDA_IN(sda_line),
        .SDA_OUT(sda_out),
        .SDA_OE_N(sda_oe_n),
        .SUB_CLOCK_OUTPUT(sub_clk),
        .SECOND_CARRY(carry),
        .ACCESS_HOLD(hold),
        .INTR_PULSE_N(intr_n)
    );
    i2c_host_model u_i2c_host_model (
        .clk(clock),
        .sda_line(sda_line),
        .scl(scl),
        .sda_rel(sda_rel)
    );

    ////////////////////////////////////////
    // trim register keeps seven bits
    function automatic logic [7:0] exp_rd(input logic [3:0] a);
        return (a == REG_TIME_TRIM_ADJUST) ? (exp_reg[a] & 8'h7F) : exp_reg[a];
    endfunction

    // Pulse output low in the first half second only when the 1 Hz pattern is set
    function automatic logic exp_pulse_n(input logic [7:0] c);
        return !(c[7:6] == CTRL1_HI_1HZ && c[3:0] == CTRL1_LO_1HZ);
    endfunction

    task automatic wb(input logic [7:0] b, input logic want);
        u_i2c_host_model.xfer(b, 1'b1, rx, ak);
        `CHK(ak, want)
    endtask

    task automatic rb(input logic [7:0] want, input logic last);
        u_i2c_host_model.xfer(8'hFF, last, rx, ak);
        `CHK(rx, want)
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            miscompares++;
            finish_test();
        end
    end

    ////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        foreach (exp_reg[i]) exp_reg[i] = REG_RESET;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        `CHK(intr_n, exp_pulse_n(exp_reg[REG_CTRL1]))
        u_i2c_host_model.start_cond();
        wb(ADR_W, 1'b1);
        wb({REG_TIME_TRIM_ADJUST, FMT_READ_NOW}, 1'b1);
        rb(exp_rd(REG_TIME_TRIM_ADJUST), 1'b1);
        u_i2c_host_model.start_cond();
        wb(ADR_W, 1'b1);
        wb({REG_CTRL1, FMT_WRITE}, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            // First byte sets the 1 Hz pulse pattern so the pulse output moves
            d = (i == 0) ? {CTRL1_HI_1HZ, 2'($random(seed)), CTRL1_LO_1HZ} : 8'($random(seed));
            exp_reg[4'(REG_CTRL1 + i)] = d;
            wb(d, 1'b1);
        end
        u_i2c_host_model.start_cond();
        wb(ADR_W, 1'b1);
        wb({REG_TIME_TRIM_ADJUST, FMT_WRITE}, 1'b1);
        d = 8'($random(seed)) | 8'h80;
        exp_reg[REG_TIME_TRIM_ADJUST] = d;
        wb(d, 1'b1);
        u_i2c_host_model.start_cond();
        wb(ADR_W, 1'b1);
        wb({REG_CTRL1, FMT_READ_NOW}, 1'b1);
        for (int i = 0; i < 4; i++)
            rb(exp_rd(4'(REG_CTRL1 + i)), i == 3);
        u_i2c_host_model.start_cond();
        wb(ADR_W, 1'b1);
        wb({4'h6, FMT_WRITE}, 1'b1);
        u_i2c_host_model.start_cond();
        wb(ADR_R, 1'b1);
        for (int i = 0; i < 3; i++)
            rb(exp_rd(4'(6 + i)), i == 2);
        u_i2c_host_model.start_cond();
        wb({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b0);
        u_i2c_host_model.stop_cond(GAP_CLKS);
        `CHK(intr_n, exp_pulse_n(exp_reg[REG_CTRL1]))
        $display("test access formats done");
        u_i2c_host_model.start_cond();
        t0 = cycles;
        wb(ADR_R, 1'b1);
        rb(exp_rd(PTR_AFTER_STOP), 1'b0);
        rb(exp_rd(4'h0), 1'b1);
        // Long idle, so a restart-based timeout would land well past the window
        repeat (3 * OSC_CLKS) @(posedge clock);
        u_i2c_host_model.start_cond();
        wb(ADR_W, 1'b1);
        wb({4'h3, FMT_WRITE}, 1'b1);
        for (int k = 0; k < 80000 && hold !== 1'b0; k++)
            @(posedge clock);
        // Release lands after REL_TICKS - 2 whole oscillator ticks plus a partial one
        `CHK((cycles - t0 >= (REL_TICKS - 2) * OSC_CLKS - 200) && (cycles - t0 <= (REL_TICKS - 1) * OSC_CLKS + 200), 1'b1)
        wb(8'($random(seed)), 1'b0);
        rb(8'hFF, 1'b1);
        `CHK(sda_out, 1'b0)
        u_i2c_host_model.stop_cond(16);
        $display("test release done");
        finish_test();
    end
endmodule
`default_nettype wire

/* verilog/rtc_access_pkg.sv */
// Shared constants of the serial register access and time trim block
package rtc_access_pkg;
    // Clock and oscillator rates
    localparam int CLK_HZ = 250_000_000;
    localparam int OSC_HZ = 32768;
    localparam logic [12:0] HALF_DIV = 13'(CLK_HZ / (2 * OSC_HZ));
    // One counted second and its half, in oscillator ticks
    localparam logic [16:0] SEC_TICKS = 17'h0_8000;
    localparam logic [16:0] HALF_SEC_TICKS = 17'h0_4000;
    // Trim applied once per this many seconds
    localparam int TRIM_PERIOD_S = 20;
    localparam logic [4:0] TRIM_LAST = 5'(TRIM_PERIOD_S - 1);
    // Automatic access release, inside the 0.5 to 1.0 s window
    localparam int RELEASE_MS = 750;
    localparam int RELEASE_TICKS = OSC_HZ * RELEASE_MS / 1000;
    // Link protocol values
    localparam logic [6:0] SLAVE_ADDR = 7'h32;
    localparam logic [3:0] FMT_WRITE = 4'h0;
    localparam logic [3:0] FMT_READ_NOW = 4'h4;
    localparam logic [3:0] PTR_AFTER_STOP = 4'hF;
    // Register map
    localparam logic [3:0] REG_TIME_TRIM_ADJUST = 4'h7;
    localparam logic [3:0] REG_CTRL1 = 4'hE;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] CTRL1_HI_1HZ = 2'h0;
    localparam logic [3:0] CTRL1_LO_1HZ = 4'h3;
    // Trim codes below these minimums give no correction; base of the gain steps
    localparam logic [6:0] TRIM_GAIN_MIN = 7'h02;
    localparam logic [6:0] TRIM_GAIN_BASE = 7'h01;
    localparam logic [6:0] TRIM_LOSS_MIN = 7'h42;
    // Write buffer shape: pointer plus data byte
    localparam int WBUF_WIDTH = 12;
    localparam int WBUF_DEPTH = 16;

    typedef enum logic [5:0] {
        ST_WAIT = 6'b00_0001,
        ST_RECV = 6'b00_0010,
        ST_ACK0 = 6'b00_0100,
        ST_ACK1 = 6'b00_1000,
        ST_SEND = 6'b01_0000,
        ST_MACK = 6'b10_0000
    } link_state_t;
endpackage

/* verilog/rtc_i2c_access_and_trim.sv */
// Serial register access engine, time-count hold and trim of the clock
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module rtc_wbuf_fifo
    import rtc_access_pkg::*;
#(
    parameter int WIDTH = WBUF_WIDTH,
    parameter int DEPTH = WBUF_DEPTH
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t n;
    logic full;
    logic empty;

    // Extra pointer bit tells full from empty
    assign full = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
    assign empty = (q.wr == q.rd);
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_data = q.mem[q.rd[AW-1:0]];

    always_comb
    begin
        n = q;
        if (in_valid && !full)
        begin
            n.mem[q.wr[AW-1:0]] = in_data;
            n.wr = q.wr + 1'b1;
        end
        if (out_ready && !empty)
        begin
            n.rd = q.rd + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module rtc_i2c_access_and_trim
    import rtc_access_pkg::*;
#(
    parameter int RELEASE_OSC_TICKS = RELEASE_TICKS
)
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    output logic SUB_CLOCK_OUTPUT,
    output logic SECOND_CARRY,
    output logic ACCESS_HOLD,
    output logic INTR_PULSE_N
);
    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
        link_state_t st;
        logic [2:0] bitc;
        logic [7:0] sr;
        logic [1:0] bidx;
        logic go_send;
        logic mack;
        logic [3:0] ptr;
        logic [3:0] fmt;
        logic sda_low;
        logic sda_o;
        logic active;
        logic locked;
        logic [15:0] rel_cnt;
        logic [12:0] half_cnt;
        logic subclk;
        logic [16:0] sec_cnt;
        logic [4:0] sec20;
        logic pend;
        logic carry;
        logic pulse_n;
        logic [15:0][7:0] regs;
    } top_state_t;

    top_state_t q;
    top_state_t n;

    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic push;
    logic [WBUF_WIDTH-1:0] push_data;
    logic push_ready;
    logic tx_load;
    logic drain_valid;
    logic [WBUF_WIDTH-1:0] drain_data;

    // Length of the current second in oscillator ticks
    function automatic logic [16:0] sec_length(input logic [6:0] adj, input logic trim_sec);
        logic [16:0] len;
        logic [6:0] steps;
        len = SEC_TICKS;
        steps = 7'h00;
        if (trim_sec)
        begin
            if (!adj[6] && adj >= TRIM_GAIN_MIN)
            begin
                steps = adj - TRIM_GAIN_BASE;
                len = SEC_TICKS + 17'({steps, 1'b0});
            end
            else if (adj[6] && adj >= TRIM_LOSS_MIN)
            begin
                steps = 7'h00 - adj;
                len = SEC_TICKS - 17'({steps, 1'b0});
            end
            // neutral codes fall through; two ticks per 3.05 ppm step
        end
        return len;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign rise = q.scl_s & ~q.scl_d;
    assign fall = ~q.scl_s & q.scl_d;
    assign start_c = q.scl_s & q.scl_d & q.sda_d & ~q.sda_s;
    assign stop_c = q.scl_s & q.scl_d & ~q.sda_d & q.sda_s;

    // Register reads stall the drain for one cycle so the array has one user
    rtc_wbuf_fifo #(
        .WIDTH(WBUF_WIDTH),
        .DEPTH(WBUF_DEPTH)
    ) u_wbuf (
        .clk(CLOCK),
        .rst(RST),
        .in_valid(push),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(drain_valid),
        .out_ready(~tx_load),
        .out_data(drain_data)
    );

    always_comb
    begin
        logic osc_tick;
        logic sec_tick;
        logic do_load;
        logic [7:0] b;
        logic [7:0] rd_byte;
        osc_tick = 1'b0;
        sec_tick = 1'b0;
        do_load = 1'b0;
        b = {q.sr[6:0], q.sda_s};
        rd_byte = 8'h00;
        push = 1'b0;
        push_data = '0;
        tx_load = 1'b0;
        n = q;
        n.carry = 1'b0;
        n.scl_m = SCL_IN;
        n.scl_s = q.scl_m;
        n.scl_d = q.scl_s;
        n.sda_m = SDA_IN;
        n.sda_s = q.sda_m;
        n.sda_d = q.sda_s;

        // free-running sub clock; no trim term here
        if (q.half_cnt == HALF_DIV - 13'h0001)
        begin
            n.half_cnt = 13'h0000;
            n.subclk = ~q.subclk;
            osc_tick = ~q.subclk;
        end
        else
        begin
            n.half_cnt = q.half_cnt + 13'h0001;
        end

        if (osc_tick)
        begin
            if (q.sec_cnt >= sec_length(q.regs[REG_TIME_TRIM_ADJUST][6:0], q.sec20 == TRIM_LAST)
                    - 17'h0_0001)
            begin
                n.sec_cnt = 17'h0_0000;
                n.sec20 = (q.sec20 == TRIM_LAST) ? 5'h00 : q.sec20 + 5'h01;
                sec_tick = 1'b1;
            end
            else
            begin
                n.sec_cnt = q.sec_cnt + 17'h0_0001;
            end
        end

        n.pulse_n = ~(q.regs[REG_CTRL1][7:6] == CTRL1_HI_1HZ
            && q.regs[REG_CTRL1][3:0] == CTRL1_LO_1HZ && q.sec_cnt < HALF_SEC_TICKS);

        // hold carries, release on next tick
        if (sec_tick && q.active)
        begin
            n.pend = 1'b1;
        end
        else if (sec_tick)
        begin
            n.carry = 1'b1;
        end
        else if (!q.active && q.pend && osc_tick)
        begin
            n.carry = 1'b1;
            n.pend = 1'b0;
        end

        if (q.active && osc_tick)
        begin
            n.rel_cnt = q.rel_cnt + 16'h0001;
        end

        if (stop_c)
        begin
            n.st = ST_WAIT;
            n.active = 1'b0;
            n.locked = 1'b0;
            n.ptr = PTR_AFTER_STOP;
            n.sda_low = 1'b0;
            n.rel_cnt = 16'h0000;
        end
        else if (q.active && q.rel_cnt >= 16'(RELEASE_OSC_TICKS - 1))
        begin
            n.st = ST_WAIT;
            n.active = 1'b0;
            n.locked = 1'b1;
            n.ptr = PTR_AFTER_STOP;
            n.sda_low = 1'b0;
            n.rel_cnt = 16'h0000;
        end
        // locked link never drives, so no acknowledge and FFh reads
        else if (start_c && !q.locked)
        begin
            n.st = ST_RECV;
            n.bitc = 3'h0;
            n.bidx = 2'h0;
            n.sda_low = 1'b0;
            if (!q.active)
            begin
                n.active = 1'b1;
                n.rel_cnt = 16'h0000;
            end
        end
        else
        begin
            case (q.st)
                ST_RECV:
                begin
                    if (rise)
                    begin
                        n.sr = b;
                        n.bitc = q.bitc + 3'h1;
                        if (q.bitc == 3'h7)
                        begin
                            n.st = ST_ACK0;
                            n.go_send = 1'b0;
                            if (q.bidx == 2'h0)
                            begin
                                if (b[7:1] == SLAVE_ADDR)
                                begin
                                    n.go_send = b[0];
                                    n.bidx = 2'h1;
                                end
                                else
                                begin
                                    n.st = ST_WAIT;
                                end
                            end
                            else if (q.bidx == 2'h1)
                            begin
                                n.ptr = b[7:4];
                                n.fmt = b[3:0];
                                n.go_send = (b[3:0] == FMT_READ_NOW);
                                n.bidx = 2'h2;
                            end
                            else if (push_ready)
                            begin
                                push = 1'b1;
                                push_data = {q.ptr, b};
                                n.ptr = q.ptr + 4'h1;
                            end
                            else
                            begin
                                // Full buffer refuses the byte with no acknowledge
                                n.st = ST_WAIT;
                            end
                        end
                    end
                end
                ST_ACK0:
                begin
                    if (fall)
                    begin
                        n.sda_low = 1'b1;
                        n.st = ST_ACK1;
                    end
                end
                ST_ACK1:
                begin
                    if (fall)
                    begin
                        n.sda_low = 1'b0;
                        n.bitc = 3'h0;
                        n.st = ST_RECV;
                        do_load = q.go_send;
                    end
                end
                ST_SEND:
                begin
                    if (fall)
                    begin
                        if (q.bitc == 3'h7)
                        begin
                            n.sda_low = 1'b0;
                            n.st = ST_MACK;
                        end
                        else
                        begin
                            n.bitc = q.bitc + 3'h1;
                            n.sr = {q.sr[6:0], 1'b0};
                            n.sda_low = ~q.sr[6];
                        end
                    end
                end
                ST_MACK:
                begin
                    if (rise)
                    begin
                        n.mack = ~q.sda_s;
                    end
                    if (fall)
                    begin
                        n.st = ST_WAIT;
                        do_load = q.mack;
                    end
                end
                default:
                begin
                    n.st = ST_WAIT;
                end
            endcase
        end

        if (do_load)
        begin
            tx_load = 1'b1;
            rd_byte = q.regs[q.ptr];
            n.sr = rd_byte;
            n.sda_low = ~rd_byte[7];
            n.bitc = 3'h0;
            n.ptr = q.ptr + 4'h1;
            n.st = ST_SEND;
        end

        if (drain_valid && !tx_load)
        begin
            n.regs[drain_data[11:8]] = drain_data[7:0];
            if (drain_data[11:8] == REG_TIME_TRIM_ADJUST)
            begin
                n.regs[REG_TIME_TRIM_ADJUST][7] = 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            q <= '0;
            q.st <= ST_WAIT;
            q.ptr <= PTR_AFTER_STOP;
            q.scl_m <= 1'b1;
            q.scl_s <= 1'b1;
            q.scl_d <= 1'b1;
            q.sda_m <= 1'b1;
            q.sda_s <= 1'b1;
            q.sda_d <= 1'b1;
            q.pulse_n <= 1'b1;
            q.regs <= {16{REG_RESET}};
        end
        else
        begin
            q <= n;
        end
    end

    assign SDA_OUT = q.sda_o;
    assign SDA_OE_N = ~q.sda_low;
    assign SUB_CLOCK_OUTPUT = q.subclk;
    assign SECOND_CARRY = q.carry;
    assign ACCESS_HOLD = q.active;
    assign INTR_PULSE_N = q.pulse_n;
endmodule

`default_nettype wire
